// ### design/btd_pkg.sv
package btd_pkg;
    // ------------------------------------------------------------
    // Register map (printed offsets are indices, byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0]  BTD_IDX_CONTROL     = 8'h0a;
    localparam logic [7:0]  BTD_IDX_TONE_SELECT = 8'h0b;
    localparam logic [11:0] BTD_ADDR_CONTROL     = {2'h0, BTD_IDX_CONTROL, 2'h0};
    localparam logic [11:0] BTD_ADDR_TONE_SELECT = {2'h0, BTD_IDX_TONE_SELECT, 2'h0};
    localparam logic [3:0]  BTD_CONTROL_RST     = 4'h0;
    localparam logic [3:0]  BTD_TONE_SELECT_RST = 4'h0;

    // ------------------------------------------------------------
    // Field positions of the control register
    // ------------------------------------------------------------
    localparam int BTD_POS_OUTPUT_POLARITY  = 3;
    localparam int BTD_POS_TONE_GATE        = 2;
    localparam int BTD_POS_SOUND_PATTERN_HI = 1;
    localparam int BTD_POS_SOUND_PATTERN_LO = 0;

    // ------------------------------------------------------------
    // Sound patterns and bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] BTD_PAT_INTERRUPTED1 = 2'h0;
    localparam logic [1:0] BTD_PAT_INTERRUPTED2 = 2'h1;
    localparam logic [1:0] BTD_PAT_SINGLE       = 2'h2;
    localparam logic [1:0] BTD_PAT_CONTINUOUS   = 2'h3;
    localparam logic [1:0] BTD_RESP_OKAY        = 2'h0;
    localparam logic [1:0] BTD_RESP_SLVERR      = 2'h2;

    // ------------------------------------------------------------
    // Timing: tone base clock and system clock
    // ------------------------------------------------------------
    localparam int BTD_CLK_HZ     = 20_000_000;
    localparam int BTD_XTAL_HZ    = 32_768;
    // Cycles of aclk per tick of the emulated crystal, rounded down
    localparam int BTD_XTAL_DIV   = BTD_CLK_HZ / BTD_XTAL_HZ;
    // Time-base envelope taps: bit index of a crystal tick counter
    localparam int BTD_TB_WIDTH   = 16;
    localparam int BTD_TAP_FAST   = 11;   // 8 Hz
    localparam int BTD_TAP_SLOW   = 13;   // 2 Hz
    localparam int BTD_TAP_SINGLE = 14;   // 1 Hz half period
endpackage

// ### design/btd_buzzer_tone_driver.sv
`timescale 1ns/1ps
// Functional notes
// - Polarity bit 0 drives positive logic; 1 inverts waveform and idle level.
// - Output only while tone gate is 1; otherwise pin holds inactive level.
// - Pattern 00 interrupted one, 01 interrupted two, 10 single, 11 continuous.
// - Tone code 0 stops output; codes 1..15 pick fifteen frequencies.
// - Reset clears both buzzer registers to zero.
module btd_buzzer_tone_driver
    import btd_pkg::*;
#(
    parameter int XTAL_DIV   = BTD_XTAL_DIV,
    parameter int TAP_FAST   = BTD_TAP_FAST,
    parameter int TAP_SLOW   = BTD_TAP_SLOW,
    parameter int TAP_SINGLE = BTD_TAP_SINGLE
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             buzzer_out,
    output logic             buzzer_active
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [3:0]  control_q;
    logic [3:0]  tone_select_q;
    logic [11:0] awaddr_q;
    logic        aw_held_q;
    logic [3:0]  wdata_q;
    logic        wstrb0_q;
    logic        w_held_q;
    logic        wr_fire;
    logic        wr_hit_ctl;
    logic        wr_hit_tone;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    // Address and data are caught independently so either may arrive first
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_hit_ctl    = awaddr_q[11:2] == BTD_ADDR_CONTROL[11:2];
    assign wr_hit_tone   = awaddr_q[11:2] == BTD_ADDR_TONE_SELECT[11:2];

    // Capture address and data halves
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= 12'h000;
            wdata_q   <= 4'h0;
            wstrb0_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata[3:0];
                wstrb0_q <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Write response, SLVERR for unmapped words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= BTD_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_hit_ctl || wr_hit_tone) ? BTD_RESP_OKAY : BTD_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes; only byte lane 0 holds the 4-bit fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_q     <= BTD_CONTROL_RST;
            tone_select_q <= BTD_TONE_SELECT_RST;
        end else if (wr_fire && wstrb0_q) begin
            if (wr_hit_ctl) begin
                control_q <= wdata_q;
            end
            if (wr_hit_tone) begin
                tone_select_q <= wdata_q;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    // One-cycle read answer; upper bits read as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= BTD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr[11:2] == BTD_ADDR_CONTROL[11:2]) begin
                s_axi_rdata <= {28'h0000000, control_q};
                s_axi_rresp <= BTD_RESP_OKAY;
            end else if (s_axi_araddr[11:2] == BTD_ADDR_TONE_SELECT[11:2]) begin
                s_axi_rdata <= {28'h0000000, tone_select_q};
                s_axi_rresp <= BTD_RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= BTD_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Crystal tick and time base
    // ------------------------------------------------------------
    logic [15:0]             xdiv_q;
    logic                    xtick;
    logic [BTD_TB_WIDTH-1:0] tb_q;
    logic                    tone_gate;
    logic                    gate_rise;
    logic                    gate_d1_q;
    logic [1:0]              pattern;

    assign tone_gate = control_q[BTD_POS_TONE_GATE];
    assign pattern   = {control_q[BTD_POS_SOUND_PATTERN_HI], control_q[BTD_POS_SOUND_PATTERN_LO]};
    assign xtick     = xdiv_q == 16'(XTAL_DIV - 1);
    assign gate_rise = tone_gate && !gate_d1_q;

    // Emulated 32.768 kHz tick; tone pitch is slightly off since 20 MHz does not divide evenly
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xdiv_q <= 16'h0000;
        end else begin
            xdiv_q <= xtick ? 16'h0000 : xdiv_q + 16'h0001;
        end
    end

    // Time base restarts on gate rise so a single sound always starts fresh
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tb_q      <= '0;
            gate_d1_q <= 1'b0;
        end else begin
            gate_d1_q <= tone_gate;
            if (gate_rise) begin
                tb_q <= '0;
            end else if (xtick) begin
                tb_q <= tb_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Tone generator
    // ------------------------------------------------------------
    logic [4:0] half_cnt_q;
    logic       tone_q;
    logic       single_done_q;
    logic       envelope;

    // Each half period lasts code+2 crystal ticks, so a full period is 2*(code+2) ticks:
    // 32768/6 gives 5.461 kHz for code 1, down to 32768/34 giving 0.964 kHz for code 15
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_cnt_q <= 5'h00;
            tone_q     <= 1'b0;
        end else if (tone_select_q == 4'h0 || !tone_gate) begin
            half_cnt_q <= 5'h00;
            tone_q     <= 1'b0;
        end else if (xtick) begin
            if (half_cnt_q == 5'h00) begin
                // Five bits because code 15 needs a count of 17 ticks
                half_cnt_q <= {1'b0, tone_select_q} + 5'h01;
                tone_q     <= !tone_q;
            end else begin
                half_cnt_q <= half_cnt_q - 5'h01;
            end
        end
    end

    // Single sound ends after one half period of the single tap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            single_done_q <= 1'b0;
        end else if (gate_rise) begin
            single_done_q <= 1'b0;
        end else if (tb_q[TAP_SINGLE]) begin
            single_done_q <= 1'b1;
        end
    end

    // Envelope per sound pattern
    always_comb begin
        unique case (pattern)
            BTD_PAT_INTERRUPTED1: envelope = !tb_q[TAP_SLOW];
            BTD_PAT_INTERRUPTED2: envelope = !tb_q[TAP_FAST] && !tb_q[TAP_SLOW];
            BTD_PAT_SINGLE:       envelope = !single_done_q;
            BTD_PAT_CONTINUOUS:   envelope = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // Pin drive, registered
    // ------------------------------------------------------------
    logic active_d;
    assign active_d = tone_gate && (tone_select_q != 4'h0) && envelope;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buzzer_out    <= 1'b0;
            buzzer_active <= 1'b0;
        end else begin
            buzzer_active <= active_d;
            buzzer_out    <= (active_d && tone_q) ^ control_q[BTD_POS_OUTPUT_POLARITY];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_gate_off_idle;
        @(posedge aclk) disable iff (!aresetn)
        !control_q[BTD_POS_TONE_GATE] |=> buzzer_out == $past(control_q[BTD_POS_OUTPUT_POLARITY]);
    endproperty
    a_gate_off_idle: assert property (p_gate_off_idle) else $error("pin not idle with gate off");

    property p_polarity;
        @(posedge aclk) disable iff (!aresetn)
        !$past(active_d) |-> buzzer_out == $past(control_q[BTD_POS_OUTPUT_POLARITY]);
    endproperty
    a_polarity: assert property (p_polarity) else $error("idle level ignores polarity");

    property p_code_zero;
        @(posedge aclk) disable iff (!aresetn)
        tone_select_q == 4'h0 |=> !buzzer_active;
    endproperty
    a_code_zero: assert property (p_code_zero) else $error("code zero not silent");

    property p_reset_clear;
        @(posedge aclk) !aresetn |=> control_q == 4'h0 && tone_select_q == 4'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared");

    property p_continuous;
        @(posedge aclk) disable iff (!aresetn)
        pattern == BTD_PAT_CONTINUOUS && tone_gate && tone_select_q != 4'h0 |=> buzzer_active;
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous tone broken");

    property p_single_ends;
        @(posedge aclk) disable iff (!aresetn)
        pattern == BTD_PAT_SINGLE && single_done_q |=> !buzzer_active;
    endproperty
    a_single_ends: assert property (p_single_ends) else $error("single sound repeats");

    property p_gate_restart;
        @(posedge aclk) disable iff (!aresetn)
        gate_rise |=> tb_q == '0;
    endproperty
    a_gate_restart: assert property (p_gate_restart) else $error("time base not restarted");

    property p_tone_stop;
        @(posedge aclk) disable iff (!aresetn)
        (tone_select_q == 4'h0 || !tone_gate) |=> !tone_q;
    endproperty
    a_tone_stop: assert property (p_tone_stop) else $error("tone runs while stopped");

    property p_active_pin;
        @(posedge aclk) disable iff (!aresetn)
        buzzer_active |-> buzzer_out == ($past(tone_q) ^ $past(control_q[BTD_POS_OUTPUT_POLARITY]));
    endproperty
    a_active_pin: assert property (p_active_pin) else $error("pin does not follow tone");

endmodule

// ### sim/btd_buzzer_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Piezo element load: counts rising swings and their spacing
// ------------------------------------------------------------
module btd_buzzer_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        buzzer_out,
    input  wire logic        clr,
    output logic [15:0]      edge_count,
    output logic [15:0]      period
);
    logic        prev_q;
    logic        seen_q;
    logic [15:0] since_q;

    // Period is only valid once two rising swings were seen since clear
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            edge_count <= 16'h0;
            period     <= 16'h0;
            seen_q     <= 1'b0;
            since_q    <= 16'h0;
            prev_q     <= buzzer_out;
        end else begin
            prev_q  <= buzzer_out;
            since_q <= since_q + 16'h1;
            if (buzzer_out && !prev_q) begin
                edge_count <= edge_count + 16'h1;
                since_q    <= 16'h1;
                seen_q     <= 1'b1;
                if (seen_q) period <= since_q;
            end
        end
    end
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import btd_pkg::*;
    localparam int XD = 4;
    logic        aclk, aresetn, clr, buzzer_out, buzzer_active;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [15:0] edge_count, period;
    int          err_count, n_compared, cyc;

    btd_buzzer_tone_driver #(.XTAL_DIV(XD), .TAP_FAST(2), .TAP_SLOW(3), .TAP_SINGLE(4)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .buzzer_out(buzzer_out), .buzzer_active(buzzer_active));
    btd_buzzer_model u_load (.aclk(aclk), .aresetn(aresetn), .buzzer_out(buzzer_out), .clr(clr),
        .edge_count(edge_count), .period(period));

    // ------------------------------------------------------------
    // Clock, watchdog, shared tasks
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Ceiling well above the roughly 7.6k cycles the scenarios need
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            results();
        end
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Ready is sampled in the low phase: inputs and flops only move at the rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
        logic a_done, w_done, a_ok, w_ok, b_ok;
        logic [1:0] r;
        a_done = 1'b0;
        w_done = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge aclk);
            a_ok = awvalid && awready;
            w_ok = wvalid && wready;
            @(posedge aclk);
            if (a_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            a_done = a_done || a_ok;
            w_done = w_done || w_ok;
        end while (!(a_done && w_done));
        do begin
            @(negedge aclk);
            b_ok = bvalid;
            r = bresp;
            @(posedge aclk);
        end while (!b_ok);
        bready <= 1'b0;
        check({30'h0, r}, {30'h0, resp});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
        logic a_ok, r_ok;
        logic [31:0] v;
        logic [1:0] r;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge aclk);
            a_ok = arready;
            @(posedge aclk);
        end while (!a_ok);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            r_ok = rvalid;
            v = rdata;
            r = rresp;
            @(posedge aclk);
        end while (!r_ok);
        rready <= 1'b0;
        check(v, d);
        check({30'h0, r}, {30'h0, resp});
    endtask

    // Counts cycles with the tone envelope open, and clears the load counters first
    task automatic watch(input int n, output int on);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        on = 0;
        repeat (n) begin
            @(negedge aclk);
            if (buzzer_active === 1'b1) on++;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(BTD_ADDR_CONTROL, 32'h0, BTD_RESP_OKAY);
        rd(BTD_ADDR_TONE_SELECT, 32'h0, BTD_RESP_OKAY);
        check({31'h0, buzzer_out}, 32'h0);
        wr(BTD_ADDR_CONTROL, 32'hfffffff9, BTD_RESP_OKAY);
        rd(BTD_ADDR_CONTROL, 32'h9, BTD_RESP_OKAY);
        wr(BTD_ADDR_TONE_SELECT, 32'h000000a5, BTD_RESP_OKAY);
        rd(BTD_ADDR_TONE_SELECT, 32'h5, BTD_RESP_OKAY);
        wr(12'h030, 32'h5, BTD_RESP_SLVERR);
        rd(12'h030, 32'h0, BTD_RESP_SLVERR);
    endtask

    // Continuous sound, every nonzero code: full period is 2*(code+2) crystal ticks
    task automatic t_freq();
        int on;
        wr(BTD_ADDR_CONTROL, 32'h7, BTD_RESP_OKAY);
        for (int c = 1; c < 16; c++) begin
            wr(BTD_ADDR_TONE_SELECT, c, BTD_RESP_OKAY);
            watch(6 * (c + 2) * XD + 8, on);
            check({16'h0, period}, 2 * (c + 2) * XD);
        end
        wr(BTD_ADDR_CONTROL, 32'hf, BTD_RESP_OKAY);
        watch(6 * 17 * XD + 8, on);
        check({16'h0, period}, 2 * 17 * XD);
    endtask

    // Stopped by code 0 or by the gate: no swings, pin at the idle level
    task automatic t_stop(input logic [3:0] ctl, input logic [3:0] code, input logic idle);
        int on;
        wr(BTD_ADDR_CONTROL, {28'h0, ctl}, BTD_RESP_OKAY);
        wr(BTD_ADDR_TONE_SELECT, {28'h0, code}, BTD_RESP_OKAY);
        watch(200, on);
        check({16'h0, edge_count}, 32'h0);
        check({31'h0, buzzer_out}, {31'h0, idle});
    endtask

    // Envelope shapes; gate is dropped first so the time base restarts
    task automatic t_patterns();
        int on0, on1, on3, ons;
        wr(BTD_ADDR_TONE_SELECT, 32'h1, BTD_RESP_OKAY);
        for (int p = 0; p < 4; p++) begin
            wr(BTD_ADDR_CONTROL, 32'h0, BTD_RESP_OKAY);
            wr(BTD_ADDR_CONTROL, 32'h4 | p, BTD_RESP_OKAY);
            watch(512, ons);
            if (p == 0) on0 = ons;
            if (p == 1) on1 = ons;
            if (p == 3) on3 = ons;
        end
        check({31'h0, on0 > 200 && on0 < 312}, 32'h1);
        check({31'h0, on1 > 80 && on1 < 176}, 32'h1);
        check(on3, 32'd512);
        wr(BTD_ADDR_CONTROL, 32'h0, BTD_RESP_OKAY);
        wr(BTD_ADDR_CONTROL, 32'h6, BTD_RESP_OKAY);
        watch(40, ons);
        check({31'h0, ons > 30}, 32'h1);
        cycles(300);
        watch(100, ons);
        check(ons, 32'h0);
        check({16'h0, edge_count}, 32'h0);
    endtask

    // Reset in mid-run must clear both registers and return the pin to positive idle
    task automatic t_reset();
        wr(BTD_ADDR_CONTROL, 32'hd, BTD_RESP_OKAY);
        wr(BTD_ADDR_TONE_SELECT, 32'h3, BTD_RESP_OKAY);
        cycles(20);
        aresetn <= 1'b0;
        cycles(3);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(BTD_ADDR_CONTROL, 32'h0, BTD_RESP_OKAY);
        rd(BTD_ADDR_TONE_SELECT, 32'h0, BTD_RESP_OKAY);
        check({31'h0, buzzer_out}, 32'h0);
    endtask

    initial begin
        aresetn = 1'b0;
        clr = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 12'h0;
        araddr = 12'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
        err_count = 0;
        n_compared = 0;
        cyc = 0;
        cycles(10);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_freq();
        t_stop(4'h7, 4'h0, 1'b0);
        t_stop(4'hf, 4'h0, 1'b1);
        t_stop(4'h3, 4'h1, 1'b0);
        t_stop(4'hb, 4'h1, 1'b1);
        t_patterns();
        t_reset();
        results();
    end
endmodule
